// ===== rtl/tocu_timer_output_compare_unit.sv
// Two-channel output compare and compare-match output logic
`timescale 1ns/10ps
`include "tocu_defines.svh"

module tocu_timer_output_compare_unit (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic timerTick,
  input wire logic [7:0] timerCount,
  input wire logic countDown,
  input wire logic counterWrite,
  input wire logic [2:0] waveModeField,
  input wire logic [1:0] compareOutputActionA,
  input wire logic [1:0] compareOutputActionB,
  input wire logic [1:0] compareWrite,
  input wire logic [7:0] compareWriteData,
  input wire logic [1:0] forceMatchStrobe,
  input wire logic flagClearWrite,
  input wire logic [1:0] flagClearData,
  input wire logic [1:0] interruptEnable,
  input wire logic [1:0] interruptServiced,
  input wire logic [1:0] portOutValue,
  input wire logic [1:0] portDirection,
  output logic [1:0] matchFlag,
  output logic [1:0] interruptRequest,
  output logic [7:0] compareValueA,
  output logic [7:0] compareValueB,
  output logic [1:0] compareOutputState,
  output tocu_pkg::tocu_pin_t [1:0] pinDrive
);

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  // Mode field decode
  function automatic tocu_pkg::tocu_wave_class_t waveClass(input logic [2:0] mode);
    begin
      case (mode)
        `TOCU_WAVE_FAST_MAX,
        `TOCU_WAVE_FAST_CMP: waveClass = tocu_pkg::TOCU_FAST_PWM;
        `TOCU_WAVE_PHASE_MAX,
        `TOCU_WAVE_PHASE_CMP: waveClass = tocu_pkg::TOCU_PHASE_PWM;
        // Reserved codes behave as non-PWM rather than freeze the unit
        default: waveClass = tocu_pkg::TOCU_NON_PWM;
      endcase
    end
  endfunction : waveClass

  // Next output state for a non-PWM match or forced match
  // Set, clear or toggle selection
  function automatic logic nonPwmNext(input logic [1:0] act, input logic cur);
    begin
      case (act)
        `TOCU_ACT_TOGGLE: nonPwmNext = ~cur;
        `TOCU_ACT_CLEAR: nonPwmNext = 1'b0;
        `TOCU_ACT_SET: nonPwmNext = 1'b1;
        default: nonPwmNext = cur;
      endcase
    end
  endfunction : nonPwmNext

  // Equality decode shared by the match, top and bottom detectors
  function automatic logic countEquals(input logic [7:0] count, input logic [7:0] value);
    begin
      countEquals = (count == value);
    end
  endfunction : countEquals

  // ----------------------------------------------------------------
  // Shared state and decode
  // ----------------------------------------------------------------
  tocu_pkg::tocu_wave_class_t waveKind;
  logic isPwm;
  logic topByCompare;
  logic [7:0] topValue;
  logic atTop;
  logic atBottom;
  logic [1:0] actionSel [`TOCU_CHANS];
  logic [7:0] activeValue [`TOCU_CHANS];
  logic [7:0] bufferValue [`TOCU_CHANS];
  logic matchBlocked;
  logic [1:0] rawMatch;
  logic [1:0] matchEvent;
  logic [1:0] matchPending;
  logic [1:0] stateReg;
  logic [1:0] forceHeld;
  logic [1:0] forceEvent;

  // Counting is outside; action is never an input to it
  assign waveKind = waveClass(waveModeField);
  assign isPwm = (waveKind != tocu_pkg::TOCU_NON_PWM);
  // Mode bit2 moves the top from the fixed maximum to channel A's value
  assign topByCompare = waveModeField[`TOCU_WAVE_BIT2];
  assign topValue = topByCompare ? activeValue[`TOCU_CHAN_A] : `TOCU_MAX;
  assign atTop = countEquals(timerCount, topValue);
  assign atBottom = countEquals(timerCount, `TOCU_BOTTOM);
  assign actionSel[0] = compareOutputActionA;
  assign actionSel[1] = compareOutputActionB;

  // ----------------------------------------------------------------
  // Match blocking after a counter write
  // ----------------------------------------------------------------
  // Block held until the next tick consumes it, even with the timer stopped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      matchBlocked <= 1'b0;
    end else if (counterWrite) begin
      matchBlocked <= 1'b1;
    end else if (timerTick) begin
      matchBlocked <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel compare, flag and output state
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < `TOCU_CHANS; ch++) begin : g_chan
      logic canToggle;
      logic next_state;

      assign rawMatch[ch] = countEquals(timerCount, activeValue[ch]);
      assign matchEvent[ch] = timerTick & rawMatch[ch] & ~matchBlocked;
      // Toggle in PWM only for channel A with compare-defined top
      assign canToggle = (ch == `TOCU_CHAN_A) && topByCompare;

      // One forced event per write, even if the strobe is held
      always_ff @(posedge core_clk) begin
        if (rst) begin
          forceHeld[ch] <= 1'h0;
        end else begin
          forceHeld[ch] <= forceMatchStrobe[ch];
        end
      end
      assign forceEvent[ch] = forceMatchStrobe[ch] & ~forceHeld[ch];

      // ----------------------------------------------------------------
      // Compare value storage
      // ----------------------------------------------------------------

      always_ff @(posedge core_clk) begin
        if (rst) begin
          bufferValue[ch] <= `TOCU_VALUE_RESET;
        end else if (compareWrite[ch]) begin
          bufferValue[ch] <= compareWriteData;
        end
      end

      always_ff @(posedge core_clk) begin
        if (rst) begin
          activeValue[ch] <= `TOCU_VALUE_RESET;
        end else if (!isPwm) begin
          if (compareWrite[ch]) begin
            activeValue[ch] <= compareWriteData;
          end
        end else if (timerTick) begin
          // Load at bottom for fast, at top for phase correct
          // Mid-period loads would give odd-length pulses
          if ((waveKind == tocu_pkg::TOCU_FAST_PWM && atBottom) ||
              (waveKind == tocu_pkg::TOCU_PHASE_PWM && atTop)) begin
            activeValue[ch] <= bufferValue[ch];
          end
        end
      end

      // ----------------------------------------------------------------
      // Match flag
      // ----------------------------------------------------------------

      // Flag follows match by one tick
      always_ff @(posedge core_clk) begin
        if (rst) begin
          matchPending[ch] <= 1'b0;
        end else if (timerTick) begin
          matchPending[ch] <= matchEvent[ch];
        end
      end

      // Hardware set wins over any clear in the same cycle
      always_ff @(posedge core_clk) begin
        if (rst) begin
          matchFlag[ch] <= 1'b0;
        end else if (timerTick && matchPending[ch]) begin
          matchFlag[ch] <= 1'b1;
        end else if (flagClearWrite && flagClearData[ch]) begin
          matchFlag[ch] <= 1'b0;
        end else if (interruptServiced[ch] && interruptEnable[ch]) begin
          matchFlag[ch] <= 1'b0;
        end
      end

      // ----------------------------------------------------------------
      // Interrupt request
      // ----------------------------------------------------------------

      always_ff @(posedge core_clk) begin
        if (rst) begin
          interruptRequest[ch] <= 1'b0;
        end else begin
          interruptRequest[ch] <= matchFlag[ch] & interruptEnable[ch];
        end
      end

      // ----------------------------------------------------------------
      // Output state
      // ----------------------------------------------------------------

      always_comb begin
        next_state = stateReg[ch];
        case (waveKind)
          tocu_pkg::TOCU_NON_PWM: begin
            // Forced match acts like a real one without flag or reload
            if (matchEvent[ch] || forceEvent[ch]) begin
              next_state = nonPwmNext(actionSel[ch], stateReg[ch]);
            end
          end
          tocu_pkg::TOCU_FAST_PWM: begin
            // Polarity: clear on match and set at bottom, or inverse
            if (matchEvent[ch]) begin
              if (actionSel[ch] == `TOCU_ACT_CLEAR) begin
                next_state = 1'b0;
              end else if (actionSel[ch] == `TOCU_ACT_SET) begin
                next_state = 1'b1;
              end else if (actionSel[ch] == `TOCU_ACT_TOGGLE && canToggle) begin
                next_state = ~stateReg[ch];
              end
            end else if (timerTick && atBottom) begin
              if (actionSel[ch] == `TOCU_ACT_CLEAR) begin
                next_state = 1'b1;
              end else if (actionSel[ch] == `TOCU_ACT_SET) begin
                next_state = 1'b0;
              end
            end
          end
          tocu_pkg::TOCU_PHASE_PWM: begin
            if (matchEvent[ch]) begin
              if (actionSel[ch] == `TOCU_ACT_CLEAR) begin
                next_state = countDown;
              end else if (actionSel[ch] == `TOCU_ACT_SET) begin
                next_state = ~countDown;
              end else if (actionSel[ch] == `TOCU_ACT_TOGGLE && canToggle) begin
                next_state = ~stateReg[ch];
              end
            end
          end
          default: next_state = stateReg[ch];
        endcase
      end

      // Reset to zero; mode change alone never touches it
      always_ff @(posedge core_clk) begin
        if (rst) begin
          stateReg[ch] <= `TOCU_STATE_RESET;
        end else begin
          stateReg[ch] <= next_state;
        end
      end

      // ----------------------------------------------------------------
      // Pin drive
      // ----------------------------------------------------------------

      // Pin drive registered, so the pin lags the port registers by a cycle
      // Override when either action bit set
      always_ff @(posedge core_clk) begin
        if (rst) begin
          pinDrive[ch].out <= `TOCU_STATE_RESET;
        end else begin
          pinDrive[ch].out <= (actionSel[ch] != `TOCU_ACT_NONE) ? next_state
                                                                : portOutValue[ch];
        end
      end

      always_ff @(posedge core_clk) begin
        if (rst) begin
          pinDrive[ch].oe <= 1'h0;
        end else begin
          pinDrive[ch].oe <= portDirection[ch];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read-back of compare values and state
  // ----------------------------------------------------------------
  // CPU sees the buffer in PWM, the active value otherwise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      compareValueA <= `TOCU_VALUE_RESET;
    end else begin
      compareValueA <= isPwm ? bufferValue[0] : activeValue[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      compareValueB <= `TOCU_VALUE_RESET;
    end else begin
      compareValueB <= isPwm ? bufferValue[1] : activeValue[1];
    end
  end

  // Registered copy keeps every output straight from a flip-flop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      compareOutputState <= '0;
    end else begin
      compareOutputState <= stateReg;
    end
  end

endmodule : tocu_timer_output_compare_unit

// ===== rtl/tocu_defines.svh
// Constants for the timer output compare unit
`ifndef TOCU_DEFINES_SVH
`define TOCU_DEFINES_SVH

// ----------------------------------------------------------------
// Counter extremes, reset values and channel constants
// ----------------------------------------------------------------
`define TOCU_BOTTOM 8'h00
`define TOCU_MAX 8'hFF
`define TOCU_VALUE_RESET 8'h00
`define TOCU_STATE_RESET 1'h0
`define TOCU_CHAN_A 0
`define TOCU_CHANS 2

// ----------------------------------------------------------------
// Waveform generation mode codes
// ----------------------------------------------------------------
`define TOCU_WAVE_NORMAL 3'h0
`define TOCU_WAVE_PHASE_MAX 3'h1
`define TOCU_WAVE_CTC 3'h2
`define TOCU_WAVE_FAST_MAX 3'h3
`define TOCU_WAVE_PHASE_CMP 3'h5
`define TOCU_WAVE_FAST_CMP 3'h7
`define TOCU_WAVE_BIT2 2

// ----------------------------------------------------------------
// Compare output action codes
// ----------------------------------------------------------------
`define TOCU_ACT_NONE 2'h0
`define TOCU_ACT_TOGGLE 2'h1
`define TOCU_ACT_CLEAR 2'h2
`define TOCU_ACT_SET 2'h3

`endif

// ===== rtl/tocu_pkg.sv
// Types shared by the timer output compare unit
package tocu_pkg;

  // ----------------------------------------------------------------
  // Waveform class decoded from the mode field
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TOCU_NON_PWM,
    TOCU_FAST_PWM,
    TOCU_PHASE_PWM
  } tocu_wave_class_t;

  // ----------------------------------------------------------------
  // Pin drive pair for one compare channel
  // ----------------------------------------------------------------
  typedef struct packed {
    logic out;
    logic oe;
  } tocu_pin_t;

endpackage : tocu_pkg

// ===== dv/tocu_checker_sva.sv
// Assertion checker for the output compare unit
`timescale 1ns/10ps
module tocu_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic timerTick,
  input wire logic [2:0] waveModeField,
  input wire logic [1:0] compareOutputActionA,
  input wire logic [1:0] compareWrite,
  input wire logic [7:0] compareWriteData,
  input wire logic [1:0] forceMatchStrobe,
  input wire logic flagClearWrite,
  input wire logic [1:0] flagClearData,
  input wire logic [1:0] interruptEnable,
  input wire logic [1:0] portOutValue,
  input wire logic [1:0] portDirection,
  input wire logic [1:0] matchFlag,
  input wire logic [1:0] interruptRequest,
  input wire logic [7:0] compareValueA,
  input wire logic [1:0] compareOutputState,
  input wire tocu_pkg::tocu_pin_t [1:0] pinDrive
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_force;
    forceMatchStrobe[0] && waveModeField == 3'h0 && compareOutputActionA == 2'h3 && !timerTick;
  endsequence
  property p_irq; !$past(rst) |-> interruptRequest == $past(matchFlag & interruptEnable);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not flag and enable");
  property p_flag_rise; $rose(matchFlag[0]) |-> $past(timerTick); endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag rose off tick");
  property p_flag_clr;
    matchFlag[0] && flagClearWrite && flagClearData[0] && !timerTick |=> !matchFlag[0];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
  property p_direct; compareWrite[0] && waveModeField == 3'h0 |->
    ##2 compareValueA == $past(compareWriteData, 2); endproperty
  a_direct: assert property (p_direct) else $error("direct compare load wrong");
  property p_force; s_force ##1 !timerTick |=> compareOutputState[0]; endproperty
  a_force: assert property (p_force) else $error("forced set missing");
  property p_keep; $changed(waveModeField) && !timerTick && !forceMatchStrobe[0] |->
    ##2 compareOutputState[0] == $past(compareOutputState[0]); endproperty
  a_keep: assert property (p_keep) else $error("state moved on mode change");
  property p_port; !$past(rst) && $past(compareOutputActionA) == 2'h0 |->
    pinDrive[0].out == $past(portOutValue[0]); endproperty
  a_port: assert property (p_port) else $error("port value not on pin");
  property p_oe; !$past(rst) |-> pinDrive[1].oe == $past(portDirection[1]); endproperty
  a_oe: assert property (p_oe) else $error("pin enable not direction");
endmodule : tocu_checker
bind tocu_timer_output_compare_unit tocu_checker tocu_checker_i (.core_clk, .rst, .timerTick,
  .waveModeField, .compareOutputActionA, .compareWrite, .compareWriteData, .forceMatchStrobe,
  .flagClearWrite, .flagClearData, .interruptEnable, .portOutValue, .portDirection,
  .matchFlag, .interruptRequest, .compareValueA, .compareOutputState, .pinDrive);

// ===== dv/tocu_count_model.sv
// Counter unit stand-in feeding timer ticks and count values
`timescale 1ns/10ps
module tocu_count_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic load,
  input wire logic [7:0] loadValue,
  output logic timerTick,
  output logic [7:0] timerCount
);
  // Tick every second clock; a load wins over counting
  always_ff @(posedge core_clk) begin
    if (rst || load) begin
      timerTick <= 1'h0;
      timerCount <= rst ? 8'h00 : loadValue;
    end else begin
      timerTick <= run & ~timerTick;
      if (timerTick) begin
        timerCount <= timerCount + 8'h01;
      end
    end
  end
endmodule : tocu_count_model

// ===== dv/tb.sv
// Self-checking bench for the timer output compare unit
`timescale 1ns/10ps
module tb;
  logic core_clk, rst, timerTick, countDown, counterWrite, flagClearWrite, run, load;
  logic [7:0] timerCount, compareWriteData, compareValueA, compareValueB, loadValue;
  logic [2:0] waveModeField;
  logic [1:0] compareOutputActionA, compareOutputActionB, compareWrite, forceMatchStrobe;
  logic [1:0] flagClearData, interruptEnable, interruptServiced, portOutValue, portDirection;
  logic [1:0] matchFlag, interruptRequest, compareOutputState;
  tocu_pkg::tocu_pin_t [1:0] pinDrive;
  int errors, cmpCount, i;
  logic [1:0] acts [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
  logic exps [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
  tocu_timer_output_compare_unit tocu_timer_output_compare_unit_i (.core_clk, .rst,
    .timerTick, .timerCount, .countDown, .counterWrite, .waveModeField, .compareOutputActionA,
    .compareOutputActionB, .compareWrite, .compareWriteData, .forceMatchStrobe,
    .flagClearWrite, .flagClearData, .interruptEnable, .interruptServiced, .portOutValue,
    .portDirection, .matchFlag, .interruptRequest, .compareValueA, .compareValueB,
    .compareOutputState, .pinDrive);
  tocu_count_model tocu_count_model_i (.core_clk, .rst, .run, .load, .loadValue,
    .timerTick, .timerCount);
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmpCount++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wcmp(input logic [1:0] m, input logic [7:0] d);
    compareWrite = m;
    compareWriteData = d;
    cyc(1);
    compareWrite = 2'h0;
  endtask : wcmp
  task frc(input logic [1:0] m);
    forceMatchStrobe = m;
    cyc(1);
    forceMatchStrobe = 2'h0;
    cyc(2);
  endtask : frc
  task ld(input logic [7:0] v);
    counterWrite = 1'h1;
    load = 1'h1;
    loadValue = v;
    cyc(1);
    counterWrite = 1'h0;
    load = 1'h0;
  endtask : ld
  task end_of_test;
    $display("errors %0d compares %0d", errors, cmpCount);
    if (errors == 0 && cmpCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task t_force;
    chk("state", 8'h00, compareOutputState);
    for (i = 0; i < 5; i++) begin
      compareOutputActionA = acts[i];
      frc(2'h1);
      chk("forced", exps[i], compareOutputState[0]);
    end
    chk("flag", 8'h00, matchFlag);
    portDirection = 2'h3;
    cyc(2);
    chk("oe", 8'h01, pinDrive[1].oe);
    chk("portout", 8'h01, pinDrive[0].out);
    compareOutputActionA = 2'h3;
    cyc(2);
    chk("override", 8'h00, pinDrive[0].out);
  endtask : t_force
  task t_match;
    wcmp(2'h1, 8'h10);
    cyc(1);
    chk("cmpA", 8'h10, compareValueA);
    interruptEnable = 2'h1;
    ld(8'h0C); // load differs from compare
    run = 1'h1;
    for (i = 0; i < 40 && matchFlag[0] !== 1'h1; i++) cyc(1);
    chk("flagA", 8'h01, matchFlag[0]);
    cyc(1);
    chk("irqA", 8'h01, interruptRequest[0]);
    run = 1'h0;
    cyc(2);
    flagClearWrite = 1'h1;
    flagClearData = 2'h2;
    cyc(1);
    chk("keep", 8'h01, matchFlag[0]);
    flagClearData = 2'h1;
    cyc(1);
    flagClearWrite = 1'h0;
    cyc(1);
    chk("clear", 8'h00, matchFlag[0]);
  endtask : t_match
  task t_block;
    compareOutputActionA = 2'h1;
    forceMatchStrobe = 2'h1;
    cyc(3);
    forceMatchStrobe = 2'h0;
    cyc(2);
    chk("oneshot", 8'h00, compareOutputState[0]);
    wcmp(2'h1, 8'h20);
    ld(8'h20);
    run = 1'h1;
    cyc(4);
    run = 1'h0;
    cyc(2);
    chk("blkflag", 8'h00, matchFlag[0]);
    chk("blkstate", 8'h00, compareOutputState[0]);
  endtask : t_block
  task t_pwm;
    wcmp(2'h2, 8'h30);
    compareOutputActionB = 2'h3;
    frc(2'h2);
    waveModeField = 3'h3;
    cyc(2);
    chk("modekeep", 8'h01, compareOutputState[1]);
    compareOutputActionB = 2'h2;
    wcmp(2'h2, 8'h50);
    cyc(1);
    chk("bufB", 8'h50, compareValueB);
    ld(8'h2E);
    run = 1'h1;
    cyc(12);
    run = 1'h0;
    chk("oldB", 8'h01, matchFlag[1]);
    chk("pwmclr", 8'h00, compareOutputState[1]);
    interruptEnable = 2'h2;
    interruptServiced = 2'h2;
    cyc(1);
    interruptServiced = 2'h0;
    chk("svcB", 8'h00, matchFlag[1]);
  endtask : t_pwm
  initial begin
    {rst, countDown, counterWrite, flagClearWrite, run, load} = 6'h20;
    {loadValue, compareWriteData, waveModeField} = 19'h0;
    {compareOutputActionA, compareOutputActionB, compareWrite, forceMatchStrobe} = 8'h0;
    {flagClearData, interruptEnable, interruptServiced, portDirection} = 8'h0;
    portOutValue = 2'h1;
    errors = 0;
    cmpCount = 0;
    cyc(4);
    rst = 1'h0;
    cyc(1);
    t_force;
    t_match;
    t_block;
    t_pwm;
    end_of_test;
  end
  initial begin
    #(50 * 2000);
    errors++;
    end_of_test;
  end
endmodule : tb
